/* File: dma_evt_pkg.sv */
// Package: register map, field layout, reset values and bus codes of the DMA event block
package dma_evt_pkg;

    // Register byte offsets on the 32-bit register bus
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_ADDRESS = 8'h04;
    localparam logic [7:0] OFS_INT_STATUS = 8'h08;
    localparam logic [7:0] OFS_INT_CLEAR = 8'h0C;
    localparam logic [7:0] OFS_INT_ENABLE = 8'h10;
    localparam logic [7:0] OFS_CHAN_ENABLE = 8'h14;
    localparam logic [7:0] OFS_CTRL_BASE = 8'h20;
    localparam logic [7:0] OFS_CTRL_LAST = 8'h3C;

    // Access status layout
    localparam int DIR_BIT = 3;
    localparam int CHAN_LSB = 0;
    localparam int CHAN_W = 3;

    // Channel event control layout
    localparam int REQ_W = 8;
    localparam int ABORT_NUM_LSB = 16;
    localparam int START_NUM_LSB = 8;
    localparam int FORCE_BIT = 7;
    localparam int ABORT_BIT = 6;
    localparam int PAT_EN_BIT = 5;
    localparam int SIRQ_EN_BIT = 4;
    localparam int AIRQ_EN_BIT = 3;

    // Values after reset
    localparam logic [7:0] REQ_NUM_RESET = 8'hFF;
    localparam logic [31:0] ADDRESS_RESET = 32'h0000_0000;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        SEL_STATUS,
        SEL_ADDRESS,
        SEL_INT_STATUS,
        SEL_INT_CLEAR,
        SEL_INT_ENABLE,
        SEL_CHAN_ENABLE,
        SEL_CTRL,
        SEL_NONE
    } reg_sel_t;

    // Address decode shared by the read and write paths
    function automatic reg_sel_t decode_f(input logic [7:0] addr);
        reg_sel_t sel;
        sel = SEL_NONE;
        if (addr[1:0] != 2'b00) begin
            sel = SEL_NONE;
        end else if (addr == OFS_STATUS) begin
            sel = SEL_STATUS;
        end else if (addr == OFS_ADDRESS) begin
            sel = SEL_ADDRESS;
        end else if (addr == OFS_INT_STATUS) begin
            sel = SEL_INT_STATUS;
        end else if (addr == OFS_INT_CLEAR) begin
            sel = SEL_INT_CLEAR;
        end else if (addr == OFS_INT_ENABLE) begin
            sel = SEL_INT_ENABLE;
        end else if (addr == OFS_CHAN_ENABLE) begin
            sel = SEL_CHAN_ENABLE;
        end else if (addr >= OFS_CTRL_BASE && addr <= OFS_CTRL_LAST) begin
            sel = SEL_CTRL;
        end
        return sel;
    endfunction : decode_f

endpackage : dma_evt_pkg

/* File: dma_channel_trigger.sv */
// Per-channel trigger decision: request matching, software strobes and abort priority
module dma_channel_trigger
    import dma_evt_pkg::*;
(
    input wire logic req_valid, // Interrupt request present this cycle
    input wire logic [REQ_W-1:0] req_number, // Number of that request
    input wire logic [REQ_W-1:0] start_number, // Channel start request number
    input wire logic [REQ_W-1:0] abort_number, // Channel abort request number
    input wire logic start_enable, // Start request enable
    input wire logic abort_enable, // Abort request enable
    input wire logic pattern_enable, // Pattern abort enable
    input wire logic pattern_hit, // Data matched channel pattern
    input wire logic force_pulse, // Software force strobe
    input wire logic abort_pulse, // Software abort strobe
    input wire logic chan_on, // Channel enable
    output logic start_hit, // Start this channel now
    output logic abort_hit, // Abort this channel now
    output logic req_abort, // Abort caused by request match
    output logic pat_abort // Abort caused by pattern match
);
    logic start_req;

    // Request matching, each gated by its own enable
    assign start_req = req_valid && start_enable && (req_number == start_number);
    assign req_abort = req_valid && abort_enable && (req_number == abort_number);
    assign pat_abort = pattern_enable && pattern_hit && chan_on;
    assign abort_hit = req_abort || abort_pulse || pat_abort;

    // An abort in the same cycle suppresses any start
    assign start_hit = chan_on && (start_req || force_pulse) && !abort_hit;
endmodule : dma_channel_trigger

/* File: dma_event_ctrl.sv */
// Top: DMA access status capture and per-channel event control behind an AXI4-Lite slave
module dma_event_ctrl
    import dma_evt_pkg::*;
#(
    parameter int NUM_CH = 8 // Number of channels, at most 8
)
(
    input wire logic clock, // System clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic ce, // Clock enable, freezes all state when low
    input wire logic [7:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [7:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic access_valid, // DMA bus access this cycle
    input wire logic access_read, // That access is a read
    input wire logic [CHAN_W-1:0] access_channel, // Channel making the access
    input wire logic [31:0] access_address, // Address of the access
    input wire logic req_valid, // Interrupt request present
    input wire logic [REQ_W-1:0] req_number, // Interrupt request number
    input wire logic [NUM_CH-1:0] pattern_match, // Per-channel pattern match pulse
    output logic [NUM_CH-1:0] start_transfer, // Start pulse per channel
    output logic [NUM_CH-1:0] abort_transfer, // Abort pulse per channel
    output logic [NUM_CH-1:0] channel_enable, // Channel enable state
    output logic irq // Level interrupt
);

    localparam int EV_W = 2 * NUM_CH;

    ////////////////////////////////////////////////////////////////////////////
    // Storage
    logic last_access_direction;
    logic [CHAN_W-1:0] last_active_channel;
    logic [31:0] last_access_address;
    logic [REQ_W-1:0] abort_request_number [NUM_CH];
    logic [REQ_W-1:0] start_request_number [NUM_CH];
    logic [NUM_CH-1:0] pattern_abort_enable;
    logic [NUM_CH-1:0] start_request_enable;
    logic [NUM_CH-1:0] abort_request_enable;
    logic [NUM_CH-1:0] force_transfer_strobe;
    logic [NUM_CH-1:0] abort_transfer_strobe;
    logic [EV_W-1:0] int_status;
    logic [EV_W-1:0] int_enable;

    // Bus slave state
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    reg_sel_t wsel;
    reg_sel_t rsel;
    logic [CHAN_W-1:0] wch;
    logic [CHAN_W-1:0] rch;
    logic [31:0] wmask;
    logic [31:0] next_rdata;
    logic [31:0] ctrl_image;
    logic [31:0] ctrl_merged;

    // Trigger results
    logic [NUM_CH-1:0] start_hit;
    logic [NUM_CH-1:0] abort_hit;
    logic [NUM_CH-1:0] req_abort;
    logic [NUM_CH-1:0] pat_abort;

    ////////////////////////////////////////////////////////////////////////////
    // Write channel: address and data taken in either order
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wsel = decode_f(aw_addr);
    assign wch = aw_addr[CHAN_W+1:2];
    assign rsel = decode_f(s_axi_araddr);
    assign rch = s_axi_araddr[CHAN_W+1:2];

    // Byte lanes turned into a bit mask
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[b*8 +: 8] = {8{w_strb[b]}};
        end
    end

    // Address and data capture; ready drops while a word is held
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (s_axi_bvalid && s_axi_bready) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (s_axi_bvalid && s_axi_bready) begin
                w_held <= 1'b0;
            end
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
        end
    end

    // Write response one cycle after both halves are held
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (ce) begin
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux; strobe bits and unused bits read as zero
    always_comb begin
        ctrl_image = 32'h0000_0000;
        ctrl_image[ABORT_NUM_LSB +: REQ_W] = abort_request_number[rch];
        ctrl_image[START_NUM_LSB +: REQ_W] = start_request_number[rch];
        ctrl_image[PAT_EN_BIT] = pattern_abort_enable[rch];
        ctrl_image[SIRQ_EN_BIT] = start_request_enable[rch];
        ctrl_image[AIRQ_EN_BIT] = abort_request_enable[rch];
        next_rdata = 32'h0000_0000;
        unique case (rsel)
            SEL_STATUS: begin
                next_rdata[DIR_BIT] = last_access_direction;
                next_rdata[CHAN_LSB +: CHAN_W] = last_active_channel;
            end
            SEL_ADDRESS: next_rdata = last_access_address;
            SEL_INT_STATUS: next_rdata[EV_W-1:0] = int_status;
            SEL_INT_CLEAR: next_rdata = 32'h0000_0000;
            SEL_INT_ENABLE: next_rdata[EV_W-1:0] = int_enable;
            SEL_CHAN_ENABLE: next_rdata[NUM_CH-1:0] = channel_enable;
            SEL_CTRL: next_rdata = (32'(rch) < NUM_CH) ? ctrl_image : 32'h0000_0000;
            SEL_NONE: next_rdata = 32'h0000_0000;
        endcase
    end

    // Read answer one cycle after the address is taken
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= next_rdata;
                s_axi_rresp <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end else if (!s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Capture of the latest DMA bus access
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            last_access_direction <= 1'b0;
            last_active_channel <= '0;
            last_access_address <= ADDRESS_RESET;
        end else if (ce && access_valid) begin
            last_access_direction <= access_read;
            last_active_channel <= access_channel;
            last_access_address <= access_address;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-channel control fields and trigger logic
    always_comb begin
        ctrl_merged = (ctrl_image_w() & ~wmask) | (w_data & wmask);
    end

    // Current control word of the channel being written
    function automatic logic [31:0] ctrl_image_w();
        logic [31:0] img;
        img = 32'h0000_0000;
        img[ABORT_NUM_LSB +: REQ_W] = abort_request_number[wch];
        img[START_NUM_LSB +: REQ_W] = start_request_number[wch];
        img[PAT_EN_BIT] = pattern_abort_enable[wch];
        img[SIRQ_EN_BIT] = start_request_enable[wch];
        img[AIRQ_EN_BIT] = abort_request_enable[wch];
        return img;
    endfunction : ctrl_image_w

    for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
        logic ctrl_wr;
        assign ctrl_wr = do_write && (wsel == SEL_CTRL) && (32'(wch) == c);

        // Control fields; strobes live one cycle only
        always_ff @(posedge clock) begin
            if (!rst_n) begin
                abort_request_number[c] <= REQ_NUM_RESET;
                start_request_number[c] <= REQ_NUM_RESET;
                pattern_abort_enable[c] <= 1'b0;
                start_request_enable[c] <= 1'b0;
                abort_request_enable[c] <= 1'b0;
                force_transfer_strobe[c] <= 1'b0;
                abort_transfer_strobe[c] <= 1'b0;
            end else if (ce) begin
                force_transfer_strobe[c] <= ctrl_wr && w_strb[0] && w_data[FORCE_BIT];
                abort_transfer_strobe[c] <= ctrl_wr && w_strb[0] && w_data[ABORT_BIT];
                if (ctrl_wr) begin
                    abort_request_number[c] <= ctrl_merged[ABORT_NUM_LSB +: REQ_W];
                    start_request_number[c] <= ctrl_merged[START_NUM_LSB +: REQ_W];
                    pattern_abort_enable[c] <= ctrl_merged[PAT_EN_BIT];
                    start_request_enable[c] <= ctrl_merged[SIRQ_EN_BIT];
                    abort_request_enable[c] <= ctrl_merged[AIRQ_EN_BIT];
                end
            end
        end

        dma_channel_trigger u_trig (
            .req_valid(req_valid),
            .req_number(req_number),
            .start_number(start_request_number[c]),
            .abort_number(abort_request_number[c]),
            .start_enable(start_request_enable[c]),
            .abort_enable(abort_request_enable[c]),
            .pattern_enable(pattern_abort_enable[c]),
            .pattern_hit(pattern_match[c]),
            .force_pulse(force_transfer_strobe[c]),
            .abort_pulse(abort_transfer_strobe[c]),
            .chan_on(channel_enable[c]),
            .start_hit(start_hit[c]),
            .abort_hit(abort_hit[c]),
            .req_abort(req_abort[c]),
            .pat_abort(pat_abort[c])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Channel enable: software writes it, a pattern abort clears it
    // The hardware clear wins over a same-cycle write so a matched channel stays stopped
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            channel_enable <= '0;
        end else if (ce) begin
            if (do_write && wsel == SEL_CHAN_ENABLE && w_strb[0]) begin
                channel_enable <= w_data[NUM_CH-1:0] & ~pat_abort;
            end else begin
                channel_enable <= channel_enable & ~pat_abort;
            end
        end
    end

    // Registered trigger pulses toward the channel data path
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            start_transfer <= '0;
            abort_transfer <= '0;
        end else if (ce) begin
            start_transfer <= start_hit;
            abort_transfer <= abort_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt flags: low half request abort, high half pattern abort; set beats clear
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            int_status <= '0;
            int_enable <= '0;
            irq <= 1'b0;
        end else if (ce) begin
            if (do_write && wsel == SEL_INT_CLEAR) begin
                int_status <= (int_status & ~(w_data[EV_W-1:0] & wmask[EV_W-1:0])) | {pat_abort, req_abort};
            end else begin
                int_status <= int_status | {pat_abort, req_abort};
            end
            if (do_write && wsel == SEL_INT_ENABLE) begin
                int_enable <= (int_enable & ~wmask[EV_W-1:0]) | (w_data[EV_W-1:0] & wmask[EV_W-1:0]);
            end
            // One cycle behind the flags; keeps the output a plain flop
            irq <= |(int_status & int_enable);
        end
    end

endmodule : dma_event_ctrl

/* File: dma_event_ctrl_asserts.sv */
// Checker: register bus and capture assertions for the DMA event block
module dma_event_ctrl_asserts
    import dma_evt_pkg::*;
#(
    parameter int NUM_CH = 8 // Channel count
)
(
    input wire logic clock, // Clock
    input wire logic rst_n, // Reset
    input wire logic ce, // Clock enable
    input wire logic [7:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // AR valid
    input wire logic s_axi_arready, // AR ready
    input wire logic [31:0] s_axi_rdata, // Read data
    input wire logic s_axi_rvalid, // R valid
    input wire logic s_axi_rready, // R ready
    input wire logic access_valid, // DMA access
    input wire logic access_read, // Direction
    input wire logic [CHAN_W-1:0] access_channel, // Channel
    input wire logic [31:0] access_address, // Address
    input wire logic [NUM_CH-1:0] start_transfer, // Starts
    input wire logic [NUM_CH-1:0] abort_transfer, // Aborts
    input wire logic [NUM_CH-1:0] channel_enable // Enables
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dc @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic [3:0] exp_stat;
    logic [31:0] exp_addr;
    logic [3:0] snap_stat;
    logic [31:0] snap_addr;
    logic [7:0] snap_ar;
    ////////////////////////////////////////////////////////////////////////////
    // Shadow capture; snapshot at AR so an access racing the read is judged alike
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            exp_stat <= 4'h0;
            exp_addr <= 32'h0;
            snap_stat <= 4'h0;
            snap_addr <= 32'h0;
            snap_ar <= 8'hFF;
        end else if (ce) begin
            if (access_valid) begin
                exp_stat <= {access_read, access_channel};
                exp_addr <= access_address;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                snap_stat <= exp_stat;
                snap_addr <= exp_addr;
                snap_ar <= s_axi_araddr;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    stat_capture_a: assert property (s_axi_rvalid && snap_ar == OFS_STATUS |-> s_axi_rdata[3:0] == snap_stat)
        else $error("status read differs from last access");
    addr_capture_a: assert property (s_axi_rvalid && snap_ar == OFS_ADDRESS |-> s_axi_rdata == snap_addr)
        else $error("address read differs from last access");
    upper_zero_a: assert property (s_axi_rvalid && snap_ar == OFS_STATUS |-> s_axi_rdata[31:4] == 28'h0)
        else $error("status upper bits not zero");
    strobe_zero_a: assert property (s_axi_rvalid && snap_ar >= OFS_CTRL_BASE && snap_ar <= OFS_CTRL_LAST |-> s_axi_rdata[7:6] == 2'b00)
        else $error("strobe bits read back nonzero");
    abort_wins_a: assert property (abort_transfer != '0 |-> (start_transfer & abort_transfer) == '0)
        else $error("start and abort together");
    start_gated_a: assert property ((start_transfer & ~$past(channel_enable)) == '0)
        else $error("start on disabled channel");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped before taken");
    ar_refuse_a: assert property (ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late or second read accepted");
endmodule : dma_event_ctrl_asserts

bind dma_event_ctrl dma_event_ctrl_asserts #(.NUM_CH(NUM_CH)) u_asserts (.clock, .rst_n, .ce, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .access_valid, .access_read,
    .access_channel, .access_address, .start_transfer, .abort_transfer, .channel_enable);

/* File: dma_far_side.sv */
// Far-side model: DMA bus accesses, interrupt requests and pattern hits
module dma_far_side
    import dma_evt_pkg::*;
#(
    parameter int NUM_CH = 8 // Channel count
)
(
    input wire logic clock, // System clock
    output logic access_valid = 1'b0, // Access strobe
    output logic access_read = 1'b0, // Access is a read
    output logic [CHAN_W-1:0] access_channel = '0, // Active channel
    output logic [31:0] access_address = 32'h0, // Access address
    output logic req_valid = 1'b0, // Request strobe
    output logic [REQ_W-1:0] req_number = 8'h00, // Request number
    output logic [NUM_CH-1:0] pattern_match = '0 // Pattern hits
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////////////////
    // Idle lines show the inverse of the last value, so a stale capture is seen
    task automatic acc(input logic rd, input logic [2:0] ch, input logic [31:0] ad);
        access_valid <= 1'b1;
        access_read <= rd;
        access_channel <= ch;
        access_address <= ad;
        @(posedge clock);
        access_valid <= 1'b0;
        access_read <= ~rd;
        access_channel <= ~ch;
        access_address <= ~ad;
    endtask : acc
    // One-cycle request or pattern pulse
    task automatic fire(input logic pat, input logic [7:0] n);
        if (pat) pattern_match <= n;
        else req_valid <= 1'b1;
        req_number <= n;
        @(posedge clock);
        pattern_match <= '0;
        req_valid <= 1'b0;
        req_number <= ~n;
    endtask : fire
endmodule : dma_far_side

/* File: tb.sv */
// Testbench: register-level tests of the DMA event block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dma_evt_pkg::*;
    logic clock = 1'b0, rst_n = 1'b0, ce = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, access_valid, access_read, req_valid, irq;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, req_number, pattern_match, start_transfer;
    logic [7:0] abort_transfer, channel_enable;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, access_address;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic [2:0] access_channel;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [31:0] d;
    int failures = 0, checks = 0;
    dma_event_ctrl #(.NUM_CH(8)) dut (.clock, .rst_n, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .access_valid, .access_read, .access_channel, .access_address, .req_valid, .req_number, .pattern_match,
        .start_transfer, .abort_transfer, .channel_enable, .irq);
    dma_far_side #(.NUM_CH(8)) p (.clock, .access_valid, .access_read, .access_channel, .access_address,
        .req_valid, .req_number, .pattern_match);
    // 100 MHz clock
    initial begin
        forever #5 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        if (failures == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // A hung handshake ends the run rather than stalling it
    task automatic guard(input int n);
        if (n >= 40) begin
            failures++;
            end_sim();
        end
    endtask : guard
    // Write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] dw, input logic [3:0] s, output logic [1:0] rs);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= dw;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clock);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 40);
        rs = s_axi_bresp;
        guard(n);
    endtask : wr
    // Read: rready comes late on purpose so the slave must hold its answer
    task automatic rd(input logic [7:0] a, output logic [31:0] dr, output logic [1:0] rs);
        int n;
        logic done;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clock);
            n++;
            done = s_axi_rvalid && s_axi_rready;
            dr = s_axi_rdata;
            rs = s_axi_rresp;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            s_axi_rready <= !done && n >= 2;
        end while (!done && n < 40);
        guard(n);
    endtask : rd
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        rd(a, d, r);
        chk(d, e);
    endtask : rchk
    // Gathers start and abort pulses over a window that covers the strobe latency
    task automatic col(input logic [7:0] es, input logic [7:0] ea);
        logic [7:0] s;
        logic [7:0] a;
        s = 8'h00;
        a = 8'h00;
        repeat (10) begin
            @(posedge clock);
            s = s | start_transfer;
            a = a | abort_transfer;
        end
        chk({24'h0, s}, {24'h0, es});
        chk({24'h0, a}, {24'h0, ea});
    endtask : col
    task automatic trig(input logic pat, input logic [7:0] n, input logic [7:0] es, input logic [7:0] ea);
        fork
            p.fire(pat, n);
            col(es, ea);
        join
    endtask : trig
    task automatic wo(input logic [7:0] a, input logic [31:0] dw, input logic [7:0] es, input logic [7:0] ea);
        logic [1:0] rs;
        fork
            wr(a, dw, 4'h1, rs);
            col(es, ea);
        join
    endtask : wo
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        rchk(OFS_ADDRESS, 32'h0);
        rchk(OFS_CTRL_BASE, 32'h00FF_FF00);
        rd(8'h18, d, r);
        chk({d[31:2], r}, {30'h0, RESP_SLVERR});
        wr(8'h1C, 32'hFFFF_FFFF, 4'hF, r);
        chk(32'(r), 32'(RESP_SLVERR));
        p.acc(1'b1, 3'h5, 32'hA5A5_1234);
        rchk(OFS_STATUS, 32'h0000_000D);
        rchk(OFS_ADDRESS, 32'hA5A5_1234);
        p.acc(1'b0, 3'h2, 32'h0000_0FFC);
        wr(OFS_STATUS, 32'hFFFF_FFFF, 4'hF, r);
        rchk(OFS_STATUS, 32'h0000_0002);
        // An access while the clock enable is low must leave the capture untouched
        ce <= 1'b0;
        p.acc(1'b1, 3'h7, 32'h0000_0001);
        ce <= 1'b1;
        rchk(OFS_STATUS, 32'h0000_0002);
        wr(OFS_CHAN_ENABLE, 32'h0000_00FF, 4'hF, r);
        wr(OFS_CTRL_BASE, 32'h00FF_0018, 4'hF, r);
        wr(8'h28, 32'h0033_3318, 4'hF, r);
        trig(1'b0, 8'h00, 8'h01, 8'h00);
        trig(1'b0, 8'hFF, 8'h00, 8'h01);
        rchk(OFS_INT_STATUS, 32'h0000_0001);
        wr(OFS_INT_ENABLE, 32'h1, 4'hF, r);
        repeat (3) @(posedge clock);
        chk(32'(irq), 32'h1);
        wr(OFS_INT_CLEAR, 32'h1, 4'hF, r);
        repeat (3) @(posedge clock);
        chk(32'(irq), 32'h0);
        trig(1'b0, 8'h33, 8'h00, 8'h04);
        wo(8'h2C, 32'h80, 8'h08, 8'h00);
        rchk(8'h2C, 32'h00FF_FF00);
        wo(8'h2C, 32'h40, 8'h00, 8'h08);
        wr(8'h30, 32'h20, 4'h1, r);
        trig(1'b1, 8'h10, 8'h00, 8'h10);
        rchk(OFS_CHAN_ENABLE, 32'h0000_00EF);
        chk({24'h0, channel_enable}, 32'h0000_00EF);
        trig(1'b1, 8'h20, 8'h00, 8'h00);
        rchk(OFS_INT_STATUS, 32'h0000_1004);
        end_sim();
    end
endmodule : tb
